// [shared/acs_pkg.sv]
// Package for the slot 12 path and converter/slot control block
`default_nettype none

package acs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ACS_OFS_TX12 = 8'h10;  // slot12_transmit_data
    localparam logic [7:0] ACS_OFS_RX12 = 8'h14;  // slot12_receive_data
    localparam logic [7:0] ACS_OFS_CTRL = 8'h18;  // converter_and_slot_control

    // Reset values
    localparam logic [31:0] ACS_RST_TX12 = 32'h0000_0000;
    localparam logic [31:0] ACS_RST_RX12 = 32'h0000_0000;
    localparam logic [31:0] ACS_RST_CTRL = 32'h0000_0000;

    // Field positions, slot 12 registers
    localparam int ACS_BIT_TX12_BUSY = 31;  // tx12_busy_flag
    localparam int ACS_BIT_TX12_LOOP = 23;  // loopback debug mode
    localparam int ACS_BIT_RX12_VALID = 31;  // rx12_valid_flag
    localparam int ACS_PAYLOAD_W = 20;  // tx12_payload / rx12_payload, bits 19:0

    // Field positions, control register
    localparam int ACS_BIT_RAM_SEL = 31;  // converter_ram_select
    localparam int ACS_BIT_CONV_RUN = 30;  // converter_run
    localparam int ACS_BIT_FILT_RUN = 29;  // converter_filter_run
    localparam int ACS_BIT_MIC_EN = 18;  // microphone_slot_enable
    localparam int ACS_BIT_LOUT_EN = 17;  // line_out_slot_enable
    localparam int ACS_BIT_SLOTS_HI = 16;  // line_in .. left_pcm_in enables
    localparam int ACS_BIT_SLOTS_LO = 12;
    localparam int ACS_BIT_OUT_RATE_LO = 3;  // left_out_rate_code, bits 5:3
    localparam int ACS_BIT_IN_RATE_LO = 0;  // left_in_rate_code, bits 2:0
    localparam logic [2:0] ACS_RATE_BAD = 3'h7;  // Prohibited rate code
    // The control struct below packs ten one-bit fields and two rate codes into 16 bits

    // Link frame timing, in link clock bits
    localparam logic [7:0] ACS_FRAME_LAST = 8'hFF;  // 256 bits per frame
    localparam logic [7:0] ACS_SYNC_BITS = 8'h10;  // Sync high over the tag slot
    localparam logic [7:0] ACS_TAG_VALID = 8'h00;  // Frame valid tag position
    localparam logic [7:0] ACS_TAG_SLOT12 = 8'h0C;  // Slot 12 valid tag position
    localparam logic [7:0] ACS_SLOT12_FIRST = 8'hEC;  // Slot 12 starts at bit 236

    // AHB transfer type
    localparam logic [1:0] ACS_HTRANS_NONSEQ = 2'h2;

    // Control outputs toward the converter and slot machinery
    typedef struct packed {
        logic ram_select;  // converter_ram_select
        logic run;  // converter_run
        logic filter_run;  // converter_filter_run, always stopped
        logic mic_en;  // microphone_slot_enable
        logic line_out_en;  // line_out_slot_enable
        logic line_in_en;  // line_in_slot_enable
        logic right_out_en;  // right_pcm_out_enable
        logic right_in_en;  // right_pcm_in_enable
        logic left_out_en;  // left_pcm_out_enable
        logic left_in_en;  // left_pcm_in_enable
        logic [2:0] left_out_rate;  // left_out_rate_code
        logic [2:0] left_in_rate;  // left_in_rate_code
    } acs_ctrl_s;

endpackage

`default_nettype wire

// [design/acs_top.sv]
// Slot 12 transmit/receive path and converter/slot control, AHB-Lite slave
//
// Chosen here: the AHB-Lite register port.
`default_nettype none


module acs_top
    import acs_pkg::*;
(
    // System clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link side, clocked by the codec bit clock
    input wire logic link_clk,
    input wire logic link_sdata_in,
    output logic link_sync,
    output logic link_sdata_out,
    // Control toward converter and slot machinery
    output acs_ctrl_s ctrl_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus-side state
    logic wr_pend_q;  // Write data phase pending
    logic rd_pend_q;  // Read data phase pending
    logic [7:0] addr_q;  // Latched byte offset
    logic busy_q;  // tx12_busy_flag
    logic loop_q;  // Loopback mode
    logic [19:0] tx_pay_q;  // tx12_payload
    logic rx_valid_q;  // rx12_valid_flag
    logic rx_fresh_q;  // Valid was set at the last edge, after read data was captured
    logic [19:0] rx_pay_q;  // rx12_payload
    acs_ctrl_s ctrl_q;  // Control register fields
    logic [31:0] hrdata_q;
    logic tx_req_tgl_q;  // Toggles once per payload handed to the link
    logic ack_s1_q, ack_s2_q, ack_seen_q;  // Sent-ack crossing
    logic rx_s1_q, rx_s2_q, rx_seen_q;  // Received-word crossing

    // Link-side state
    logic lrst_s1_q, lrst_n_q;  // Link reset, released in link domain
    logic req_s1_q, req_s2_q, req_seen_q;  // Request crossing
    logic [7:0] bit_cnt_q;  // Position within the frame
    logic [19:0] tx_word_q;  // Payload captured for sending
    logic have_q;  // Word waiting for next frame
    logic send_q;  // Word goes out in this frame
    logic ack_tgl_q;  // Toggles when slot 12 has gone out
    logic rx_tag_q;  // Codec marked slot 12 valid
    logic [19:0] rx_shift_q;
    logic [19:0] rx_word_q;  // Completed received word, held a frame
    logic rx_tgl_q;  // Toggles per received word
    logic sync_q, sdo_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Register read assembly; reserved bits come out as zero
    function automatic logic [31:0] rd_word(input logic [7:0] ofs);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (ofs == ACS_OFS_TX12) begin
            w[ACS_BIT_TX12_BUSY] = busy_q;
            w[ACS_BIT_TX12_LOOP] = loop_q;
            w[ACS_PAYLOAD_W-1:0] = tx_pay_q;
        end else if (ofs == ACS_OFS_RX12) begin
            w[ACS_BIT_RX12_VALID] = rx_valid_q;
            w[ACS_PAYLOAD_W-1:0] = rx_pay_q;
        end else if (ofs == ACS_OFS_CTRL) begin
            w[ACS_BIT_RAM_SEL] = ctrl_q.ram_select;
            w[ACS_BIT_CONV_RUN] = ctrl_q.run;
            w[ACS_BIT_FILT_RUN] = ctrl_q.filter_run;
            w[ACS_BIT_MIC_EN] = ctrl_q.mic_en;
            w[ACS_BIT_LOUT_EN] = ctrl_q.line_out_en;
            w[ACS_BIT_SLOTS_HI:ACS_BIT_SLOTS_LO] = {ctrl_q.line_in_en, ctrl_q.right_out_en,
                ctrl_q.right_in_en, ctrl_q.left_out_en, ctrl_q.left_in_en};
            w[ACS_BIT_OUT_RATE_LO+2:ACS_BIT_OUT_RATE_LO] = ctrl_q.left_out_rate;
            w[ACS_BIT_IN_RATE_LO+2:ACS_BIT_IN_RATE_LO] = ctrl_q.left_in_rate;
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire logic addr_ok = hsel && hready && (htrans == ACS_HTRANS_NONSEQ);
    wire logic wr_tx12 = wr_pend_q && (addr_q == ACS_OFS_TX12);
    wire logic wr_ctrl = wr_pend_q && (addr_q == ACS_OFS_CTRL);
    // Payload is refused while busy so the link never sees a torn word
    wire logic pay_take = wr_tx12 && !busy_q;
    wire logic new_loop = hwdata[ACS_BIT_TX12_LOOP];
    wire logic tx_launch = pay_take && !new_loop;
    wire logic loop_copy = pay_take && new_loop;
    wire logic rd_rx12 = rd_pend_q && (addr_q == ACS_OFS_RX12);
    wire logic ack_evt = ack_s2_q != ack_seen_q;
    wire logic rx_evt = rx_s2_q != rx_seen_q;
    wire logic [2:0] wr_out_rate = hwdata[ACS_BIT_OUT_RATE_LO+2:ACS_BIT_OUT_RATE_LO];
    wire logic [2:0] wr_in_rate = hwdata[ACS_BIT_IN_RATE_LO+2:ACS_BIT_IN_RATE_LO];

    // Address phase capture and registered read data, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            rd_pend_q <= addr_ok && !hwrite;
            addr_q <= haddr[7:0];
            // Unmapped offsets read as zero
            hrdata_q <= (addr_ok && !hwrite && haddr[31:8] == 24'h000000) ?
                rd_word(haddr[7:0]) : 32'h0000_0000;
        end
    end

    // Slot 12 transmit register and busy flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= ACS_RST_TX12[ACS_BIT_TX12_BUSY];
            loop_q <= ACS_RST_TX12[ACS_BIT_TX12_LOOP];
            tx_pay_q <= ACS_RST_TX12[ACS_PAYLOAD_W-1:0];
            tx_req_tgl_q <= 1'b0;
        end else begin
            if (wr_tx12) begin
                loop_q <= new_loop;
            end
            if (pay_take) begin
                tx_pay_q <= hwdata[ACS_PAYLOAD_W-1:0];
            end
            if (tx_launch) begin
                busy_q <= 1'b1;
                tx_req_tgl_q <= ~tx_req_tgl_q;
            end else if (ack_evt) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Any event that posts a word into the receive register
    wire logic rx_set = loop_copy || (rx_evt && !loop_q);

    // Slot 12 receive register; a new word wins over a read clear.
    // A word posted on a read's address edge was not in the captured data, so that
    // read must not clear it: the word would otherwise be lost unseen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_valid_q <= ACS_RST_RX12[ACS_BIT_RX12_VALID];
            rx_pay_q <= ACS_RST_RX12[ACS_PAYLOAD_W-1:0];
            rx_fresh_q <= 1'b0;
        end else begin
            rx_fresh_q <= rx_set;
            if (loop_copy) begin
                rx_pay_q <= hwdata[ACS_PAYLOAD_W-1:0];
                rx_valid_q <= 1'b1;
            end else if (rx_evt && !loop_q) begin
                // Word is held stable for a whole frame on the link side
                rx_pay_q <= rx_word_q;
                rx_valid_q <= 1'b1;
            end else if (rd_rx12 && !rx_fresh_q) begin
                rx_valid_q <= 1'b0;
            end
        end
    end

    // Control register; prohibited rate codes keep the previous setting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= acs_ctrl_s'(ACS_RST_CTRL[$bits(acs_ctrl_s)-1:0]);
        end else if (wr_ctrl) begin
            ctrl_q.ram_select <= hwdata[ACS_BIT_RAM_SEL];
            ctrl_q.run <= hwdata[ACS_BIT_CONV_RUN];
            ctrl_q.filter_run <= 1'b0;
            ctrl_q.mic_en <= hwdata[ACS_BIT_MIC_EN];
            ctrl_q.line_out_en <= hwdata[ACS_BIT_LOUT_EN];
            {ctrl_q.line_in_en, ctrl_q.right_out_en, ctrl_q.right_in_en, ctrl_q.left_out_en,
                ctrl_q.left_in_en} <= hwdata[ACS_BIT_SLOTS_HI:ACS_BIT_SLOTS_LO];
            if (wr_out_rate != ACS_RATE_BAD) begin
                ctrl_q.left_out_rate <= wr_out_rate;
            end
            if (wr_in_rate != ACS_RATE_BAD) begin
                ctrl_q.left_in_rate <= wr_in_rate;
            end
        end
    end

    // Crossings from the link domain into hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_seen_q <= 1'b0;
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
            rx_seen_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_seen_q <= ack_s2_q;
            rx_s1_q <= rx_tgl_q;
            rx_s2_q <= rx_s1_q;
            rx_seen_q <= rx_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain reset: asserts at once, releases on the link clock
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            lrst_s1_q <= 1'b0;
            lrst_n_q <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            lrst_n_q <= lrst_s1_q;
        end
    end

    // Frame position and outgoing bit selection
    wire logic req_evt = req_s2_q != req_seen_q;
    wire logic frame_end = bit_cnt_q == ACS_FRAME_LAST;
    wire logic in_slot12 = bit_cnt_q >= ACS_SLOT12_FIRST;
    wire logic [4:0] s12_idx = 5'(bit_cnt_q - ACS_SLOT12_FIRST);
    wire logic [4:0] s12_msb = 5'(ACS_PAYLOAD_W - 1);
    // Bit 0 leaves on the same edge that loads send_q, so the frame tag looks at the
    // pending word itself; the slot tag later in the frame can use send_q
    wire logic tag_valid = (bit_cnt_q == ACS_TAG_VALID) && have_q;
    wire logic tag_slot = (bit_cnt_q == ACS_TAG_SLOT12) && send_q;
    wire logic tag_bit = tag_valid || tag_slot;
    wire logic data_bit = in_slot12 && send_q && tx_word_q[s12_msb - s12_idx];

    // Request crossing, frame counter and slot 12 transmit
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_seen_q <= 1'b0;
            bit_cnt_q <= 8'h00;
            tx_word_q <= 20'h00000;
            have_q <= 1'b0;
            send_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            sync_q <= 1'b0;
            sdo_q <= 1'b0;
        end else begin
            req_s1_q <= tx_req_tgl_q;
            req_s2_q <= req_s1_q;
            req_seen_q <= req_s2_q;
            bit_cnt_q <= bit_cnt_q + 8'h01;
            sync_q <= bit_cnt_q < ACS_SYNC_BITS;
            sdo_q <= tag_bit || data_bit;
            // Bus payload is frozen while busy, so it is safe to sample here
            if (req_evt) begin
                tx_word_q <= tx_pay_q;
                have_q <= 1'b1;
            end else if (bit_cnt_q == ACS_TAG_VALID) begin
                have_q <= 1'b0;
            end
            if (bit_cnt_q == ACS_TAG_VALID) begin
                send_q <= have_q;
            end else if (frame_end && send_q) begin
                send_q <= 1'b0;
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    // Slot 12 receive from the codec
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            rx_tag_q <= 1'b0;
            rx_shift_q <= 20'h00000;
            rx_word_q <= 20'h00000;
            rx_tgl_q <= 1'b0;
        end else begin
            if (bit_cnt_q == ACS_TAG_SLOT12) begin
                rx_tag_q <= link_sdata_in;
            end
            if (in_slot12) begin
                rx_shift_q <= {rx_shift_q[18:0], link_sdata_in};
            end
            if (frame_end && rx_tag_q) begin
                rx_word_q <= {rx_shift_q[18:0], link_sdata_in};
                rx_tgl_q <= ~rx_tgl_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs; hreadyout and hresp are constants, the rest come from flip-flops
    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link_sync = sync_q;
    assign link_sdata_out = sdo_q;
    assign ctrl_out = ctrl_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_busy_set: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_launch |=> busy_q) else $error("busy not set after payload write");
    chk_busy_read: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_ok && !hwrite && haddr[7:0] == ACS_OFS_TX12 && haddr[31:8] == 24'h0)
        |=> hrdata_q[31] == $past(busy_q)) else $error("busy bit misread");
    chk_busy_ends: assert property (@(posedge hclk) disable iff (!hresetn)
        ack_evt && !tx_launch |=> !busy_q) else $error("busy not released");
    chk_loop_copy: assert property (@(posedge hclk) disable iff (!hresetn)
        loop_copy |=> rx_valid_q && rx_pay_q == $past(hwdata[19:0]))
        else $error("loopback copy missing");
    chk_payload_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_q |=> $stable(tx_pay_q)) else $error("payload changed while busy");
    chk_valid_set: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_evt && !loop_q && !loop_copy |=> rx_valid_q && rx_pay_q == $past(rx_word_q))
        else $error("received word not posted");
    chk_valid_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_rx12 && !rx_fresh_q && !rx_evt && !loop_copy |=> !rx_valid_q)
        else $error("valid not cleared");
    chk_fresh_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_rx12 && rx_fresh_q |=> rx_valid_q) else $error("unread word cleared");
    chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_pend_q |-> hrdata_q[28:24] == 5'h00 && hrdata_q[22:20] == 3'h0)
        else $error("reserved bits nonzero");
    chk_filter_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q.filter_run) else $error("filter running");
    chk_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> ctrl_q.ram_select == $past(hwdata[31]) && ctrl_q.run == $past(hwdata[30])
        && ctrl_q.mic_en == $past(hwdata[18]) && ctrl_q.line_out_en == $past(hwdata[17]))
        else $error("control bits not stored");
    chk_rate_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_q.left_out_rate != ACS_RATE_BAD && ctrl_q.left_in_rate != ACS_RATE_BAD)
        else $error("prohibited rate stored");
    chk_slots_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> ctrl_q.line_in_en == $past(hwdata[16]) && ctrl_q.left_in_en ==
        $past(hwdata[12])) else $error("slot enables not stored");
    chk_sent_frame: assert property (@(posedge link_clk) disable iff (!lrst_n_q)
        (bit_cnt_q == ACS_TAG_VALID && have_q && !req_evt) |=> send_q)
        else $error("pending word not sent");
    cov_tx_done: cover property (@(posedge hclk) disable iff (!hresetn) busy_q ##1 !busy_q);
    cov_rx_word: cover property (@(posedge hclk) disable iff (!hresetn) rx_evt);
    cov_loop: cover property (@(posedge hclk) disable iff (!hresetn) loop_copy);
    cov_frame_tag: cover property (@(posedge link_clk) disable iff (!lrst_n_q) tag_valid);
    cov_read_clr: cover property (@(posedge hclk) disable iff (!hresetn) rd_rx12 && rx_valid_q);

endmodule

`default_nettype wire

// [verif/acs_codec_model.sv]
// Behavioural codec model at the far end of the serial link
`default_nettype none

module acs_codec_model
    import acs_pkg::*;
(
    // Link pins
    input wire logic link_clk,
    input wire logic link_sync,
    input wire logic link_sdata_out,
    output logic link_sdata_in,
    // Bench side
    input wire logic tx_arm,
    input wire logic [19:0] tx_word,
    output logic [19:0] rx_word,
    output logic [7:0] rx_cnt,
    output logic [7:0] tx_cnt
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] pos = 8'h00;  // Bit position in the frame
    logic [7:0] p, nb;  // Position of this edge, bit driven next
    logic sync_prev = 1'b0;
    logic sending = 1'b0;  // This frame carries a slot 12 word
    logic tag0 = 1'b0, tag12 = 1'b0;  // Frame and slot tags of the incoming frame
    logic [19:0] sh = 20'h0, wq = 20'h0;

    initial begin
        link_sdata_in = 1'b0;
        rx_word = 20'h0;
        rx_cnt = 8'h00;
        tx_cnt = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sync rise realigns the count; input bits lead by two since both sides register
    always @(posedge link_clk) begin
        p = (link_sync && !sync_prev) ? 8'h00 : pos + 8'h01;
        nb = p + 8'h02;
        sync_prev <= link_sync;
        pos <= p;
        if (p == ACS_TAG_VALID) tag0 <= link_sdata_out;
        if (p == ACS_TAG_SLOT12) tag12 <= link_sdata_out;
        if (p >= ACS_SLOT12_FIRST) sh <= {sh[18:0], link_sdata_out};
        if (p == ACS_FRAME_LAST && tag0 && tag12) begin
            rx_word <= {sh[18:0], link_sdata_out};
            rx_cnt <= rx_cnt + 8'h01;
        end
        // Decide before bit 0 of the next frame is driven
        if (p == 8'hFD) begin
            sending <= tx_arm;
            wq <= tx_word;
        end
        // Count once the last bit of a carried frame is driven, before sending moves on
        if (p == 8'hFD && sending) tx_cnt <= tx_cnt + 8'h01;
        // Idle frames carry zeros
        if (!sending) link_sdata_in <= 1'b0;
        else if (nb == ACS_TAG_VALID || nb == ACS_TAG_SLOT12) link_sdata_in <= 1'b1;
        else if (nb >= ACS_SLOT12_FIRST) link_sdata_in <= wq[5'(8'hFF - nb)];
        else link_sdata_in <= 1'b0;
    end
endmodule

`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the slot 12 path and converter/slot control
`default_nettype none

module testbench
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic hclk = 1'b0, link_clk = 1'b0, hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, tx_arm = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;  // Whole words only
    logic [19:0] tx_word = 20'h0, rx_word;
    logic [31:0] hrdata;
    logic hreadyout, hresp, link_sdata_in, link_sync, link_sdata_out;
    logic [7:0] rx_cnt, tx_cnt;
    acs_ctrl_s ctrl_out;
    int mismatches = 0, n_tests = 0, cyc = 0;

    acs_top acs_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link_clk(link_clk), .link_sdata_in(link_sdata_in), .link_sync(link_sync),
        .link_sdata_out(link_sdata_out), .ctrl_out(ctrl_out));
    acs_codec_model acs_codec_model_i (.link_clk(link_clk), .link_sync(link_sync),
        .link_sdata_out(link_sdata_out), .link_sdata_in(link_sdata_in), .tx_arm(tx_arm),
        .tx_word(tx_word), .rx_word(rx_word), .rx_cnt(rx_cnt), .tx_cnt(tx_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    // Clocks: link clock offset so the two never line up
    initial begin
        forever #25 hclk = ~hclk;
    end
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    task automatic give_verdict();
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One single transfer; entered just after a rising edge. Ready and read data are
    // taken at the rising edge that ends each phase, before that edge's updates land.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= ACS_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(a, 1'b1, d, v);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(a, 1'b0, 32'h0, v);
        chk(v, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, then an unmapped place that must stay empty
    task automatic t_reset();
        rd_chk(ACS_OFS_TX12, ACS_RST_TX12);
        rd_chk(ACS_OFS_RX12, ACS_RST_RX12);
        rd_chk(ACS_OFS_CTRL, ACS_RST_CTRL);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd_chk(8'h1C, 32'h0000_0000);
    endtask

    // Control fields, reserved and filter bits, refused rate code, every legal code
    task automatic t_ctrl();
        acs_ctrl_s e;
        logic [31:0] v;
        wr(ACS_OFS_CTRL, 32'hFFFF_EFEE);
        rd_chk(ACS_OFS_CTRL, 32'hC007_E02E);
        e = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h5, 3'h6};
        chk({16'h0, ctrl_out}, {16'h0, e});
        wr(ACS_OFS_CTRL, 32'h0000_103F);
        rd_chk(ACS_OFS_CTRL, 32'h0000_102E);
        for (int k = 0; k < 7; k++) begin
            v = {26'h0, 3'(k), 3'(6 - k)};
            wr(ACS_OFS_CTRL, v);
            rd_chk(ACS_OFS_CTRL, v);
        end
    endtask

    // Send a word: busy while pending, write while busy ignored, word on the wire
    task automatic t_tx();
        logic [31:0] v;
        logic [7:0] c;
        c = rx_cnt;
        wr(ACS_OFS_TX12, 32'h7F7A_BCDE);
        rd_chk(ACS_OFS_TX12, 32'h800A_BCDE);
        wr(ACS_OFS_TX12, 32'h0001_2345);
        rd_chk(ACS_OFS_TX12, 32'h800A_BCDE);
        v = 32'h8000_0000;
        for (int i = 0; i < 400 && v[31]; i++) bus(ACS_OFS_TX12, 1'b0, 32'h0, v);
        chk(v, 32'h000A_BCDE);
        chk({24'h0, 8'(rx_cnt - c)}, 32'h1);
        chk({12'h0, rx_word}, 32'h000A_BCDE);
    endtask

    // Receive a word from the codec; valid clears after the first read
    task automatic t_rx();
        logic [31:0] v;
        logic [7:0] c;
        c = tx_cnt;
        tx_word <= 20'h5_A5A5;
        tx_arm <= 1'b1;
        for (int i = 0; i < 2000 && tx_cnt == c; i++) @(posedge hclk);
        tx_arm <= 1'b0;
        v = 32'h0;
        for (int i = 0; i < 40 && !v[31]; i++) bus(ACS_OFS_RX12, 1'b0, 32'h0, v);
        chk(v, 32'h8005_A5A5);
        rd_chk(ACS_OFS_RX12, 32'h0005_A5A5);
    endtask

    // Loopback: written word appears in receive without going busy
    task automatic t_loop();
        wr(ACS_OFS_TX12, 32'h0083_3CC3);
        rd_chk(ACS_OFS_RX12, 32'h8003_3CC3);
        rd_chk(ACS_OFS_TX12, 32'h0083_3CC3);
        rd_chk(ACS_OFS_RX12, 32'h0003_3CC3);
        wr(ACS_OFS_TX12, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard: all scenarios fit well inside this many cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_ctrl();
        t_tx();
        t_rx();
        t_loop();
        give_verdict();
    end
endmodule

`default_nettype wire
